// ==== rtl/dct_pkg.sv ====
// dct_pkg: command codes, link sample layout, argument fields, timing counts
// assumes the controller makes the link clock from sys_clk by a divider
package dct_pkg;
  localparam int SYS_PS = 50000;
  localparam int CK_HALF = 4;
  localparam int CK_PS = SYS_PS * 2 * CK_HALF;
  localparam int CNT_W = 8;
  typedef logic [CNT_W-1:0] dct_cnt_t;

  typedef enum logic [2:0] {
    DCT_NOP = 3'h0,
    DCT_MRS = 3'h1,
    DCT_REF = 3'h2,
    DCT_PRE = 3'h3,
    DCT_ACT = 3'h4,
    DCT_WR = 3'h5,
    DCT_RD = 3'h6,
    DCT_ZQS = 3'h7
  } dct_cmd_t;

  localparam int ARG_W = 8;
  localparam int ARG_WR_LSB = 0;
  localparam int ARG_WR_W = 4;
  localparam int ARG_BC4_BIT = 4;
  localparam int ARG_MPR_BIT = 5;

  typedef struct packed {
    logic rst_n;
    logic ck;
    logic cke;
    logic odt;
    logic bc4;
    dct_cmd_t cmd;
    logic [ARG_W-1:0] arg;
  } dct_link_t;

  // ceiling of ps over the clock period, never below floor_n
  function automatic int dct_nck(input int ps, input int floor_n);
    int c;
    c = (ps + CK_PS - 1) / CK_PS;
    return (c > floor_n) ? c : floor_n;
  endfunction

  localparam int MRD_NCK = 4;
  localparam int SHORT_CALIBRATION_COMMAND_NCK = 64;
  localparam int XP_PS = 7500;
  localparam int XP_MIN_NCK = 3;
  localparam int XP_NCK = dct_nck(XP_PS, XP_MIN_NCK);
  localparam int XPDLL_PS = 24000;
  localparam int XPDLL_MIN_NCK = 10;
  localparam int XPDLL_NCK = dct_nck(XPDLL_PS, XPDLL_MIN_NCK);
  localparam int CKE_PS = 5625;
  localparam int CKE_MIN_NCK = 3;
  localparam int CKE_NCK = dct_nck(CKE_PS, CKE_MIN_NCK);
  localparam int WR_PS = 15000;
  localparam int WR_NCK = dct_nck(WR_PS, 1);
  localparam int RP_PS = 13750;
  localparam int RP_NCK = dct_nck(RP_PS, 1);
  localparam int RFC_PS = 260000;
  localparam int RFC_NCK = dct_nck(RFC_PS, 1);
  localparam int REFI_PS = 7800000;
  localparam int REFI_NCK = REFI_PS / CK_PS;
  localparam int REF_OWED_MAX = 8;
  localparam int REFPDEN_NCK = 1;
  localparam int ODTH_SHORT_NCK = 4;
  localparam int ODTH_LONG_NCK = 6;
  localparam int BURST_LONG_NCK = 4;
  localparam int BURST_SHORT_NCK = 2;
  localparam int RD_PD_EXTRA_NCK = 1;
  localparam int MPRR_NCK = 1;
  localparam int INIT_RST_NCK = 8;
  localparam int WL_DEF = 5;
  localparam int RL_DEF = 6;
endpackage

// ==== rtl/dct_link_if.sv ====
// dct_link_if: the command link between controller and memory
// assumes the controller drives every wire and the memory only listens
`timescale 1ns/10ps
interface dct_link_if;
  logic rst_n;
  logic ck;
  logic cke;
  logic odt;
  logic bc4;
  dct_pkg::dct_cmd_t cmd;
  logic [dct_pkg::ARG_W-1:0] arg;
  modport ctrl (output rst_n, ck, cke, odt, bc4, cmd, arg);
  modport dram (input rst_n, ck, cke, odt, bc4, cmd, arg);
endinterface

// ==== rtl/dct_dram.sv ====
// dct_dram: memory end; samples the link, times writes, calibration, power
// assumes link wires arrive unsynchronised and change near falling ck edges
`timescale 1ns/10ps
module dct_dram #(
  parameter int WL = dct_pkg::WL_DEF
) (
  input wire logic sys_clk,
  input wire logic reset,
  dct_link_if.dram link,
  output logic wr_start,
  output logic zq_busy,
  output logic pd_low_power,
  output logic timing_fault,
  output logic [dct_pkg::ARG_WR_W-1:0] wr_recovery
);
  if (WL < 1 || WL + dct_pkg::BURST_LONG_NCK + 15 > 255) begin : g_chk
    $error("dct_dram: WL out of range");
  end
  localparam int PIPE_W = WL + dct_pkg::BURST_LONG_NCK;

  typedef struct packed {
    dct_pkg::dct_link_t s1;
    dct_pkg::dct_link_t s2;
    logic ck_q;
    logic cke_q;
    logic odt_q;
    logic bc4_fixed;
    logic wr_start;
    logic fault;
    logic pd_lp;
    logic [dct_pkg::ARG_WR_W-1:0] wr_rec;
    dct_pkg::dct_cnt_t mrd;
    dct_pkg::dct_cnt_t zq;
    logic [PIPE_W-1:0] wr_pipe;
    dct_pkg::dct_cnt_t op;
    dct_pkg::dct_cnt_t xp;
    dct_pkg::dct_cnt_t xpdll;
  } dct_dram_st_t;

  dct_dram_st_t q_reg;
  dct_dram_st_t q_next;
  dct_pkg::dct_link_t pin;
  logic rise;
  logic live;

  function automatic dct_pkg::dct_cnt_t dct_dec(input dct_pkg::dct_cnt_t c);
    return (c != '0) ? c - 1'b1 : c;
  endfunction

  assign pin = {link.rst_n, link.ck, link.cke, link.odt, link.bc4, link.cmd, link.arg};

  always_comb begin
    q_next = q_reg;
    q_next.s1 = pin;
    q_next.s2 = q_reg.s1;
    q_next.ck_q = q_reg.s2.ck;
    q_next.wr_start = 1'b0;
    rise = q_reg.s2.ck && !q_reg.ck_q;
    live = q_reg.s2.cke && q_reg.cke_q;
    if (rise) begin
      // every check below counts sampled edges, not time
      q_next.mrd = dct_dec(q_reg.mrd);
      q_next.zq = dct_dec(q_reg.zq);
      q_next.wr_pipe = q_reg.wr_pipe >> 1;
      q_next.op = dct_dec(q_reg.op);
      q_next.xp = dct_dec(q_reg.xp);
      q_next.xpdll = dct_dec(q_reg.xpdll);
      q_next.cke_q = q_reg.s2.cke;
      q_next.odt_q = q_reg.s2.odt;
      if (q_reg.wr_pipe[0]) begin
        q_next.wr_start = 1'b1;
      end
      if (q_reg.s2.cke && !q_reg.cke_q) begin
        q_next.xp = dct_pkg::dct_cnt_t'(dct_pkg::XP_NCK - 1);
        q_next.xpdll = dct_pkg::dct_cnt_t'(dct_pkg::XPDLL_NCK - 1);
      end
      if (live && q_reg.s2.cmd != dct_pkg::DCT_NOP) begin
        if (q_reg.zq != '0 || q_reg.xp != '0) begin
          q_next.fault = 1'b1;
        end
      end
      if (live && q_reg.s2.odt && !q_reg.odt_q && q_reg.xpdll != '0) begin
        q_next.fault = 1'b1;
      end
      if (live) begin
        case (q_reg.s2.cmd)
          dct_pkg::DCT_MRS: begin
            if (q_reg.mrd != '0) begin
              q_next.fault = 1'b1;
            end
            q_next.mrd = dct_pkg::dct_cnt_t'(dct_pkg::MRD_NCK - 1);
            q_next.wr_rec = q_reg.s2.arg[dct_pkg::ARG_WR_LSB +: dct_pkg::ARG_WR_W];
            q_next.bc4_fixed = q_reg.s2.arg[dct_pkg::ARG_BC4_BIT];
          end
          dct_pkg::DCT_ZQS: begin
            q_next.zq = dct_pkg::dct_cnt_t'(dct_pkg::SHORT_CALIBRATION_COMMAND_NCK - 1);
          end
          dct_pkg::DCT_WR: begin
            // otf chop still starts after the long burst
            // one bit per write in flight, so back-to-back writes each start
            if (q_reg.bc4_fixed) begin
              q_next.wr_pipe[WL + dct_pkg::BURST_SHORT_NCK - 1] = 1'b1;
            end else begin
              q_next.wr_pipe[PIPE_W - 1] = 1'b1;
            end
            q_next.op = dct_pkg::dct_cnt_t'(WL + dct_pkg::BURST_LONG_NCK)
              + dct_pkg::dct_cnt_t'(q_reg.wr_rec);
          end
          dct_pkg::DCT_RD: begin
            if (q_reg.xpdll != '0) begin
              q_next.fault = 1'b1;
            end
          end
          dct_pkg::DCT_ACT, dct_pkg::DCT_PRE: begin
            q_next.op = dct_pkg::dct_cnt_t'(dct_pkg::RP_NCK - 1);
          end
          dct_pkg::DCT_REF: begin
            q_next.op = dct_pkg::dct_cnt_t'(dct_pkg::RFC_NCK - 1);
          end
          default: begin
          end
        endcase
      end
      if (!q_reg.s2.rst_n) begin
        // reset pin clears the fault: reinitialisation starts here
        q_next = '0;
        q_next.s1 = pin;
        q_next.s2 = q_reg.s1;
        q_next.ck_q = q_reg.s2.ck;
      end
    end
    // counters keep running with cke low; low power only when idle
    q_next.pd_lp = !q_reg.s2.cke && q_reg.cke_q == 1'b0 && q_reg.op == '0
      && q_reg.zq == '0 && q_reg.wr_pipe == '0;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign wr_start = q_reg.wr_start;
  assign zq_busy = q_reg.zq != '0;
  assign pd_low_power = q_reg.pd_lp;
  assign timing_fault = q_reg.fault;
  assign wr_recovery = q_reg.wr_rec;
endmodule

// ==== rtl/dct_ctrl.sv ====
// dct_ctrl: controller end; makes the link clock and spaces every command
// assumes the user holds req_valid and its fields until req_ready
`timescale 1ns/10ps
module dct_ctrl #(
  parameter int WL = dct_pkg::WL_DEF,
  parameter int RL = dct_pkg::RL_DEF
) (
  input wire logic sys_clk,
  input wire logic reset,
  dct_link_if.ctrl link,
  input wire logic req_valid,
  input wire dct_pkg::dct_cmd_t req_cmd,
  input wire logic req_bc4,
  input wire logic [dct_pkg::ARG_W-1:0] req_arg,
  output logic req_ready,
  input wire logic pd_req,
  input wire logic odt_req,
  input wire logic [dct_pkg::ARG_W-1:0] init_arg,
  input wire logic restart,
  output logic init_done,
  output logic in_power_down,
  output logic [3:0] ref_owed
);
  if (WL < 1 || RL < 1 || WL + RL + 32 > 255) begin : g_chk_lat
    $error("dct_ctrl: WL or RL out of range");
  end
  if (dct_pkg::CK_HALF < 1 || dct_pkg::CK_HALF > 8) begin : g_chk_div
    $error("dct_ctrl: clock divider out of range");
  end

  typedef enum logic [1:0] {
    ST_RST = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10,
    ST_PD = 2'b11
  } dct_ctrl_state_t;

  typedef struct packed {
    logic [2:0] div;
    logic ck;
    dct_ctrl_state_t state;
    logic rst_n;
    logic cke;
    logic odt;
    logic bc4;
    dct_pkg::dct_cmd_t cmd;
    logic [dct_pkg::ARG_W-1:0] arg;
    dct_pkg::dct_cnt_t gap;
    dct_pkg::dct_cnt_t pd_gap;
    dct_pkg::dct_cnt_t dll_gap;
    dct_pkg::dct_cnt_t odt_cnt;
    dct_pkg::dct_cnt_t mpr_gap;
    dct_pkg::dct_cnt_t ref_t;
    dct_pkg::dct_cnt_t init_cnt;
    logic [3:0] owed;
    logic mpr_on;
    logic bc4_fixed;
    logic [dct_pkg::ARG_WR_W-1:0] wr_rec;
  } dct_ctrl_st_t;

  localparam logic [2:0] DIV_LAST = 3'(dct_pkg::CK_HALF - 1);
  localparam logic [3:0] OWED_MAX = 4'(dct_pkg::REF_OWED_MAX);

  dct_ctrl_st_t q_reg;
  dct_ctrl_st_t q_next;
  logic tick;
  logic take;
  logic force_ref;
  logic legal;
  logic [dct_pkg::ARG_W-1:0] mr_arg;
  dct_pkg::dct_cmd_t issue;
  int wr_cyc;

  function automatic dct_pkg::dct_cnt_t dct_dec(input dct_pkg::dct_cnt_t c);
    return (c != '0) ? c - 1'b1 : c;
  endfunction

  function automatic dct_pkg::dct_cnt_t dct_max(input dct_pkg::dct_cnt_t a,
                                                 input int b);
    return (a > dct_pkg::dct_cnt_t'(b)) ? a : dct_pkg::dct_cnt_t'(b);
  endfunction

  always_comb begin
    q_next = q_reg;
    take = 1'b0;
    legal = 1'b0;
    mr_arg = '0;
    issue = dct_pkg::DCT_NOP;
    wr_cyc = 0;
    force_ref = q_reg.owed >= OWED_MAX;
    // divider: link clock toggles every CK_HALF sys cycles
    if (q_reg.div == DIV_LAST) begin
      q_next.div = '0;
      q_next.ck = !q_reg.ck;
    end else begin
      q_next.div = q_reg.div + 3'h1;
    end
    // commands change at the falling edge, memory samples at the rising one
    tick = (q_reg.div == DIV_LAST) && q_reg.ck;
    if (tick) begin
      // one decrement per link clock cycle, never per unit of time
      q_next.cmd = dct_pkg::DCT_NOP;
      q_next.bc4 = 1'b0;
      q_next.gap = dct_dec(q_reg.gap);
      q_next.pd_gap = dct_dec(q_reg.pd_gap);
      q_next.dll_gap = dct_dec(q_reg.dll_gap);
      q_next.odt_cnt = dct_dec(q_reg.odt_cnt);
      q_next.mpr_gap = dct_dec(q_reg.mpr_gap);
      if (q_reg.state == ST_RUN || q_reg.state == ST_PD) begin
        // divider is fixed, so edges stand for time here
        if (q_reg.ref_t == dct_pkg::dct_cnt_t'(dct_pkg::REFI_NCK - 1)) begin
          q_next.ref_t = '0;
          if (q_reg.owed < OWED_MAX) begin
            q_next.owed = q_reg.owed + 4'h1;
          end
        end else begin
          q_next.ref_t = q_reg.ref_t + 1'b1;
        end
      end
      case (q_reg.state)
        ST_RST: begin
          q_next.rst_n = 1'b0;
          q_next.cke = 1'b0;
          q_next.odt = 1'b0;
          if (q_reg.init_cnt == dct_pkg::dct_cnt_t'(dct_pkg::INIT_RST_NCK - 1)) begin
            q_next.rst_n = 1'b1;
            q_next.cke = 1'b1;
            q_next.gap = dct_pkg::dct_cnt_t'(dct_pkg::XPDLL_NCK - 1);
            q_next.state = ST_WAIT;
          end else begin
            q_next.init_cnt = q_reg.init_cnt + 1'b1;
          end
        end
        ST_WAIT: begin
          if (q_reg.gap == '0) begin
            issue = dct_pkg::DCT_MRS;
            mr_arg = init_arg;
            q_next.state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (odt_req && !q_reg.odt && q_reg.dll_gap == '0) begin
            q_next.odt = 1'b1;
            q_next.odt_cnt = dct_max(q_next.odt_cnt, dct_pkg::ODTH_SHORT_NCK - 1);
          end else if (!odt_req && q_reg.odt && q_reg.odt_cnt == '0) begin
            q_next.odt = 1'b0;
          end
          legal = !(req_cmd == dct_pkg::DCT_RD && q_reg.dll_gap != '0)
            && !(req_cmd == dct_pkg::DCT_MRS && q_reg.mpr_gap != '0);
          if (q_reg.gap == '0) begin
            if (force_ref || (q_reg.owed != '0 && !req_valid)) begin
              issue = dct_pkg::DCT_REF;
              q_next.owed = q_next.owed - 4'h1;
            end else if (req_valid && legal) begin
              issue = req_cmd;
              mr_arg = req_arg;
              take = 1'b1;
            end else if (pd_req && q_reg.pd_gap == '0 && !q_reg.odt) begin
              // operations may still be finishing inside the memory
              q_next.cke = 1'b0;
              q_next.gap = dct_pkg::dct_cnt_t'(dct_pkg::CKE_NCK - 1);
              q_next.state = ST_PD;
            end
          end
        end
        ST_PD: begin
          if (q_reg.gap == '0 && (!pd_req || force_ref)) begin
            q_next.cke = 1'b1;
            q_next.gap = dct_pkg::dct_cnt_t'(dct_pkg::XP_NCK - 1);
            q_next.dll_gap = dct_pkg::dct_cnt_t'(dct_pkg::XPDLL_NCK - 1);
            q_next.state = ST_RUN;
          end
        end
        default: begin
          q_next.state = ST_RST;
        end
      endcase
      q_next.cmd = issue;
      case (issue)
        dct_pkg::DCT_MRS: begin
          q_next.arg = mr_arg;
          q_next.wr_rec = mr_arg[dct_pkg::ARG_WR_LSB +: dct_pkg::ARG_WR_W];
          q_next.bc4_fixed = mr_arg[dct_pkg::ARG_BC4_BIT];
          q_next.mpr_on = mr_arg[dct_pkg::ARG_MPR_BIT];
          q_next.gap = dct_pkg::dct_cnt_t'(dct_pkg::MRD_NCK - 1);
          q_next.pd_gap = dct_max(q_next.pd_gap, dct_pkg::MRD_NCK - 1);
        end
        dct_pkg::DCT_ZQS: begin
          q_next.gap = dct_pkg::dct_cnt_t'(dct_pkg::SHORT_CALIBRATION_COMMAND_NCK - 1);
          q_next.pd_gap = dct_max(q_next.pd_gap, dct_pkg::SHORT_CALIBRATION_COMMAND_NCK - 1);
        end
        dct_pkg::DCT_REF: begin
          q_next.gap = dct_pkg::dct_cnt_t'(dct_pkg::RFC_NCK - 1);
          // extra exit-lock time before cke may drop after refresh
          q_next.pd_gap = dct_max(q_next.pd_gap, (dct_pkg::XPDLL_NCK
            > dct_pkg::REFPDEN_NCK ? dct_pkg::XPDLL_NCK : dct_pkg::REFPDEN_NCK) - 1);
        end
        dct_pkg::DCT_ACT, dct_pkg::DCT_PRE: begin
          q_next.gap = dct_pkg::dct_cnt_t'(dct_pkg::RP_NCK - 1);
        end
        dct_pkg::DCT_WR: begin
          q_next.bc4 = req_bc4;
          // rounded-up recovery, at least the programmed field
          wr_cyc = (int'(q_reg.wr_rec) > dct_pkg::WR_NCK) ? int'(q_reg.wr_rec)
            : dct_pkg::WR_NCK;
          wr_cyc = wr_cyc + WL - 1 + (q_reg.bc4_fixed ? dct_pkg::BURST_SHORT_NCK
            : dct_pkg::BURST_LONG_NCK);
          q_next.pd_gap = dct_max(q_next.pd_gap, wr_cyc);
          if (q_next.odt) begin
            if (q_reg.bc4_fixed || req_bc4) begin
              q_next.odt_cnt = dct_max(q_next.odt_cnt, dct_pkg::ODTH_SHORT_NCK - 1);
            end else begin
              q_next.odt_cnt = dct_max(q_next.odt_cnt, dct_pkg::ODTH_LONG_NCK - 1);
            end
          end
        end
        dct_pkg::DCT_RD: begin
          q_next.pd_gap = dct_max(q_next.pd_gap,
            RL + dct_pkg::BURST_LONG_NCK + dct_pkg::RD_PD_EXTRA_NCK - 1);
          if (q_reg.mpr_on) begin
            q_next.mpr_gap = dct_max(q_next.mpr_gap,
              RL + dct_pkg::BURST_LONG_NCK + dct_pkg::MPRR_NCK - 1);
          end
        end
        default: begin
        end
      endcase
    end
    if (restart) begin
      // any timing fault: reset the memory and run initialisation again
      q_next = '0;
      // divider keeps running so link clock halves stay whole
      q_next.div = (q_reg.div == DIV_LAST) ? 3'h0 : q_reg.div + 3'h1;
      q_next.ck = (q_reg.div == DIV_LAST) ? !q_reg.ck : q_reg.ck;
      // command wires change only at a falling edge
      q_next.cmd = tick ? dct_pkg::DCT_NOP : q_reg.cmd;
      q_next.bc4 = tick ? 1'b0 : q_reg.bc4;
      q_next.arg = q_reg.arg;
      take = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign link.rst_n = q_reg.rst_n;
  assign link.ck = q_reg.ck;
  assign link.cke = q_reg.cke;
  assign link.odt = q_reg.odt;
  assign link.bc4 = q_reg.bc4;
  assign link.cmd = q_reg.cmd;
  assign link.arg = q_reg.arg;
  assign req_ready = take;
  assign init_done = q_reg.state == ST_RUN || q_reg.state == ST_PD;
  assign in_power_down = q_reg.state == ST_PD;
  assign ref_owed = q_reg.owed;
endmodule

// ==== test/dct_link_assertions.sv ====
// dct_link_assertions: spacing checks on the link between controller and memory
// assumes every link wire changes only at sys_clk edges and reset clears both ends
`timescale 1ns/10ps
module dct_link_assertions (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic rst_n,
  input wire logic ck,
  input wire logic cke,
  input wire logic odt,
  input wire logic bc4,
  input wire dct_pkg::dct_cmd_t cmd,
  input wire logic [dct_pkg::ARG_W-1:0] arg
);
  localparam int GAP_MAX = 9 * dct_pkg::REFI_NCK;
  localparam int MPR_MIN = dct_pkg::RL_DEF + dct_pkg::BURST_LONG_NCK + dct_pkg::MPRR_NCK;
  logic ck_q, cke_q, odt_q, chop_reg, mpr_reg;
  logic [7:0] mrs_c, zq_c, xp_c, ref_c, odt_c, wr8_c, mpr_c;
  logic fall, issue, long_wr;
  assign fall = ck_q & ~ck;
  assign issue = fall & (cmd != dct_pkg::DCT_NOP);
  assign long_wr = issue & (cmd == dct_pkg::DCT_WR) & ~bc4 & ~chop_reg & odt;
  function automatic logic [7:0] up(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction
  // link ticks since each event, sys cycles for odt and long writes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ck_q <= 1'b0;
      cke_q <= 1'b0;
      odt_q <= 1'b0;
      chop_reg <= 1'b0;
      mrs_c <= 8'hFF;
      zq_c <= 8'hFF;
      xp_c <= 8'hFF;
      ref_c <= 8'h00;
      odt_c <= 8'h00;
      wr8_c <= 8'hFF;
      mpr_reg <= 1'b0;
      mpr_c <= 8'hFF;
    end else begin
      ck_q <= ck;
      cke_q <= cke;
      odt_q <= odt;
      if (issue && cmd == dct_pkg::DCT_MRS) chop_reg <= arg[dct_pkg::ARG_BC4_BIT];
      if (issue && cmd == dct_pkg::DCT_MRS) mrs_c <= 8'h01;
      else if (fall) mrs_c <= up(mrs_c);
      if (issue && cmd == dct_pkg::DCT_ZQS) zq_c <= 8'h01;
      else if (fall) zq_c <= up(zq_c);
      if (cke && !cke_q) xp_c <= {7'h00, fall};
      else if (fall) xp_c <= up(xp_c);
      if (!rst_n || (issue && cmd == dct_pkg::DCT_REF)) ref_c <= 8'h00;
      else if (fall) ref_c <= up(ref_c);
      if (odt && !odt_q) odt_c <= 8'h01;
      else if (odt) odt_c <= up(odt_c);
      if (long_wr) wr8_c <= 8'h01;
      else wr8_c <= up(wr8_c);
      if (issue && cmd == dct_pkg::DCT_MRS) mpr_reg <= arg[dct_pkg::ARG_MPR_BIT];
      if (issue && cmd == dct_pkg::DCT_RD && mpr_reg) mpr_c <= 8'h01;
      else if (fall) mpr_c <= up(mpr_c);
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  ck_half_a: assert property ($rose(ck) |-> ck [*4] ##1 !ck)
    else $error("link clock high half wrong");
  cmd_edge_a: assert property ($changed(cmd) |-> !ck)
    else $error("command changed while clock high");
  mrs_gap_a: assert property (issue && cmd == dct_pkg::DCT_MRS |-> mrs_c >= 4)
    else $error("mode set spacing short");
  zq_quiet_a: assert property (issue |-> zq_c >= 64)
    else $error("command inside calibration window");
  exit_wait_a: assert property (issue |-> xp_c >= 3)
    else $error("command too soon after clock enable rise");
  dll_read_a: assert property (issue && cmd == dct_pkg::DCT_RD |-> xp_c >= 10)
    else $error("read before dll wait");
  dll_odt_a: assert property ($rose(odt) |-> xp_c >= 10)
    else $error("odt rise before dll wait");
  odt_short_a: assert property ($fell(odt) |-> odt_c >= 25)
    else $error("odt high time below four ticks");
  odt_long_a: assert property ($fell(odt) |-> wr8_c >= 41)
    else $error("odt high time below six ticks after long write");
  ref_gap_a: assert property (ref_c <= GAP_MAX)
    else $error("refresh gap above nine intervals");
  mpr_recovery_a: assert property (issue && cmd == dct_pkg::DCT_MRS |-> mpr_c >= MPR_MIN)
    else $error("mode set too soon after register read");
endmodule

// ==== test/tb.sv ====
// tb: drives the controller user side, watches the memory end outputs
// assumes both ends meet on dct_link_if and share sys_clk and reset
`timescale 1ns/10ps
module tb;
  localparam int WL = dct_pkg::WL_DEF;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic req_bc4 = 1'b0;
  logic pd_req = 1'b0;
  logic odt_req = 1'b0;
  logic kick = 1'b0;
  logic chop = 1'b0;
  logic ck_d = 1'b0;
  dct_pkg::dct_cmd_t req_cmd = dct_pkg::DCT_NOP;
  logic [7:0] req_arg = 8'h00;
  logic [7:0] init_arg = 8'h00;
  logic [3:0] max_owed = 4'h0;
  logic req_ready, init_done, in_power_down, wr_start, zq_busy, pd_low_power, timing_fault;
  logic [3:0] ref_owed, wr_recovery;
  int num_errors = 0;
  int tests_run = 0;
  int rises = 0;
  int exp_q[$];
  int stamp_q[$];
  dct_pkg::dct_cmd_t cmds[6] = '{dct_pkg::DCT_ACT, dct_pkg::DCT_WR, dct_pkg::DCT_PRE,
    dct_pkg::DCT_REF, dct_pkg::DCT_ZQS, dct_pkg::DCT_RD};
  dct_link_if link();
  dct_ctrl dct_ctrl_inst (.sys_clk(sys_clk), .reset(reset), .link(link),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_bc4(req_bc4), .req_arg(req_arg),
    .req_ready(req_ready), .pd_req(pd_req), .odt_req(odt_req), .init_arg(init_arg),
    .restart(timing_fault | kick), .init_done(init_done), .in_power_down(in_power_down),
    .ref_owed(ref_owed));
  dct_dram dct_dram_inst (.sys_clk(sys_clk), .reset(reset), .link(link), .wr_start(wr_start),
    .zq_busy(zq_busy), .pd_low_power(pd_low_power), .timing_fault(timing_fault),
    .wr_recovery(wr_recovery));
  dct_link_assertions dct_link_assertions_inst (.sys_clk(sys_clk), .reset(reset),
    .rst_n(link.rst_n), .ck(link.ck), .cke(link.cke), .odt(link.odt), .bc4(link.bc4),
    .cmd(link.cmd), .arg(link.arg));
  always #25 sys_clk = ~sys_clk;
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return init_done;
      1: return zq_busy;
      2: return in_power_down;
      3: return pd_low_power;
      4: return link.odt;
      5: return link.ck;
      default: return logic'(exp_q.size() == 0);
    endcase
  endfunction
  task automatic wait_sig(input string what, input int s, input logic v);
    int n;
    logic r;
    n = 0;
    while (sig(s) !== v && n < 5000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    r = sig(s);
    chk(what, 16'(v), 16'(r));
    if (r !== v) finish_test();
  endtask
  task automatic send(input dct_pkg::dct_cmd_t c, input logic b, input logic [7:0] a);
    int n;
    logic r;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b1;
    req_cmd = c;
    req_bc4 = b;
    req_arg = a;
    n = 0;
    do begin
      @(negedge sys_clk);
      r = req_ready;
      @(posedge sys_clk);
      n++;
    end while (r !== 1'b1 && n < 5000);
    #1;
    req_valid = 1'b0;
    if (r !== 1'b1) chk("req_ready", 16'h1, 16'(r));
    if (r !== 1'b1) finish_test();
    if (c == dct_pkg::DCT_WR) exp_q.push_back(WL + (chop ? 3 : 5));
    if (c == dct_pkg::DCT_MRS) chop = a[dct_pkg::ARG_BC4_BIT];
  endtask
  // link clock rises counted from each write issue to the internal start
  always @(posedge sys_clk) begin
    if (link.ck === 1'b1 && ck_d === 1'b0) rises++;
    if (link.ck === 1'b0 && ck_d === 1'b1 && link.cmd === dct_pkg::DCT_WR) begin
      stamp_q.push_back(rises);
    end
    if (ref_owed > max_owed) max_owed = ref_owed;
    if (wr_start === 1'b1 && (exp_q.size() == 0 || stamp_q.size() == 0)) begin
      chk("wr_start spurious", 16'h0, 16'h1);
    end else if (wr_start === 1'b1) begin
      chk("wr_start delay", 16'(exp_q.pop_front()), 16'(rises - stamp_q.pop_front()));
    end
    ck_d = link.ck;
  end
  initial begin
    logic [3:0] wrf;
    int d;
    void'($urandom(23296));
    init_arg = {4'h0, 4'($urandom_range(15, 1))};
    repeat (5) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    wait_sig("init_done", 0, 1'b1);
    repeat (16) @(posedge sys_clk);
    #1;
    chk("wr_recovery", 16'(init_arg[3:0]), 16'(wr_recovery));
    for (int k = 0; k < 2; k++) begin
      wrf = 4'($urandom_range(15, 1));
      send(dct_pkg::DCT_MRS, 1'b0, {2'h0, k[0], k[0], wrf});
      for (int j = 0; j < 3; j++) send(dct_pkg::DCT_WR, 1'($urandom), 8'h00);
      wait_sig("writes done", 6, 1'b1);
      chk("wr_recovery", 16'(wrf), 16'(wr_recovery));
    end
    foreach (cmds[i]) send(cmds[i], 1'b0, 8'h00);
    send(dct_pkg::DCT_MRS, 1'b0, {4'h0, wrf});
    send(dct_pkg::DCT_ZQS, 1'b0, 8'h00);
    wait_sig("zq_busy", 1, 1'b1);
    d = rises;
    wait_sig("zq_busy", 1, 1'b0);
    chk("zq window", 16'h1, 16'((rises - d) inside {[62:64]}));
    send(dct_pkg::DCT_REF, 1'b0, 8'h00);
    pd_req = 1'b1;
    wait_sig("in_power_down", 2, 1'b1);
    wait_sig("pd_low_power", 3, 1'b1);
    pd_req = 1'b0;
    odt_req = 1'b1;
    send(dct_pkg::DCT_RD, 1'b0, 8'h00);
    send(dct_pkg::DCT_WR, 1'b0, 8'h00);
    odt_req = 1'b0;
    wait_sig("odt low", 4, 1'b0);
    odt_req = 1'b1;
    wait_sig("odt high", 4, 1'b1);
    odt_req = 1'b0;
    wait_sig("odt low", 4, 1'b0);
    wait_sig("writes done", 6, 1'b1);
    chk("timing_fault", 16'h0, 16'(timing_fault));
    pd_req = 1'b1;
    wait_sig("in_power_down", 2, 1'b1);
    wait_sig("forced exit", 2, 1'b0);
    pd_req = 1'b0;
    chk("max ref_owed", 16'h8, 16'(max_owed));
    wait_sig("ck high", 5, 1'b1);
    wait_sig("ck low", 5, 1'b0);
    kick = 1'b1;
    @(posedge sys_clk);
    #1;
    kick = 1'b0;
    chk("init_done", 16'h0, 16'(init_done));
    wait_sig("init_done", 0, 1'b1);
    finish_test();
  end
endmodule
